// ===== common/cfg_consts.svh
// Purpose: Constants for the charge flag and discharge gauging block
// Assumes: 32-bit plain register port, byte addressing
// Notes:   Offsets are byte addresses of aligned words
// Overview of operation
// - Full flag clears when soc at/below threshold
// - Full flag sets when soc at/above threshold
// - Full flag clears when voltage at/below threshold
// - Full flag sets when voltage at/above threshold
// - Empty flag clears when soc at/above threshold
// - Empty flag sets when soc at/below threshold
// - Empty flag clears when voltage at/above threshold
// - Empty flag sets when voltage at/below threshold
// - Smoothing to final threshold needs all controls
// - Learning optionally needs prior full charge
// - Learned capacity capped at design capacity
// - Fixed or dynamic final threshold when compensated
// - Charger type selects learning optimisation
// - Compensation bit picks model or fixed thresholds
// - Sync remaining to full capacity at termination
// - Uncompensated mode uses stored fixed thresholds
// - Highest threshold follows battery low setting when compensated
// - Overload current halts threshold detection
// - Learning disqualified below low temperature limit
// - Near full capacity starts qualified discharge
// - Report zero remaining while reserve remains
// - Cycle counted per capacity times percentage
// - Termination sets gauging full charge bit
`ifndef CFG_CONSTS_SVH
`define CFG_CONSTS_SVH
`define CFG_OFS_FLAG_CFG     8'h00
`define CFG_OFS_GAUGE_CFG    8'h04
`define CFG_OFS_STATUS       8'h08
`define CFG_OFS_FIX_FINAL_DISCHARGE_THRESHOLD     8'h0C
`define CFG_OFS_FIX_EDV1     8'h10
`define CFG_OFS_FIX_HIGHEST_DISCHARGE_THRESHOLD     8'h14
`define CFG_OFS_FC_SOC       8'h18
`define CFG_OFS_FD_SOC       8'h1C
`define CFG_OFS_FC_VOLT      8'h20
`define CFG_OFS_FD_VOLT      8'h24
`define CFG_OFS_LIMITS       8'h28
`define CFG_OFS_NEAR_FULL    8'h3C
`define CFG_OFS_RESERVE      8'h40
`define CFG_FLAG_CFG_RST     8'h8C
`define CFG_GAUGE_CFG_RST    16'h0000
`define CFG_FC_SET_SOC_RST   8'h64
`define CFG_FC_CLR_SOC_RST   8'h5F
`define CFG_FD_SET_SOC_RST   8'h00
`define CFG_FD_CLR_SOC_RST   8'h05
`define CFG_B_STAT_GFC       2
`define CFG_B_FC_CLR_SOC     7
`define CFG_B_FC_SET_SOC     6
`define CFG_B_FC_CLR_V       5
`define CFG_B_FC_SET_V       4
`define CFG_B_FD_CLR_SOC     3
`define CFG_B_FD_SET_SOC     2
`define CFG_B_FD_CLR_V       1
`define CFG_B_FD_SET_V       0
`define CFG_B_SMOOTH0        12
`define CFG_B_LEARN_FC       10
`define CFG_B_LEARNED_CAPACITY_CAP_EN      8
`define CFG_B_FIXED_FINAL_THRESHOLD_SEL     5
`define CFG_B_CHARGER        4
`define CFG_B_COMP           3
`define CFG_B_CAPACITY_SYNC_EN          1
`define CFG_B_CCT            0
`define CFG_GAUGE_CFG_MASK   16'h153B
`endif

// ===== common/cfg_pkg.sv
// Purpose: Types for the charge flag and discharge gauging block
// Assumes: Constants live in cfg_consts.svh
// Notes:   Learning state enumeration and a 16-bit word type
package cfg_pkg;
    typedef enum logic [1:0] {CFG_LRN_IDLE, CFG_LRN_ARMED, CFG_LRN_RUN} cfg_lrn_e;
    typedef logic [15:0] cfg_word_t;
endpackage : cfg_pkg

// ===== rtl/cfg_flag_gauge.sv
// Purpose: Full/empty flag logic and discharge gauging configuration
// Assumes: Measurement inputs synchronous, valid strobe per new result
// Notes:   Arithmetic of compensation model is outside; this block steers it
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "cfg_consts.svh"
module cfg_flag_gauge #(
    parameter int W = 16
) (
    input  wire logic          mclk_in,
    input  wire logic          rstn_in,
    input  wire logic          ce_in,
    input  wire logic [7:0]    addr_in,
    input  wire logic [31:0]   wdata_in,
    input  wire logic          wr_in,
    input  wire logic          rd_in,
    output logic      [31:0]   rdata_out,
    input  wire logic          meas_valid_in,
    input  wire logic [7:0]    soc_in,
    input  wire logic [W-1:0]  volt_in,
    input  wire logic [W-1:0]  dsg_current_in,
    input  wire logic [W-1:0]  temp_in,
    input  wire logic [W-1:0]  remcap_in,
    input  wire logic [W-1:0]  fcc_learned_in,
    input  wire logic [W-1:0]  design_cap_in,
    input  wire logic [W-1:0]  model_final_discharge_threshold_in,
    input  wire logic [W-1:0]  model_edv1_in,
    input  wire logic [W-1:0]  model_highest_discharge_threshold_in,
    input  wire logic [W-1:0]  battery_low_edv_in,
    input  wire logic          smoothing_enable_ctl_in,
    input  wire logic          smoothing_extension_ctl_in,
    input  wire logic          charge_term_in,
    input  wire logic          discharging_in,
    output logic               full_charge_flag_out,
    output logic               full_discharge_flag_out,
    output logic               gauge_full_charge_out,
    output logic [W-1:0]       final_discharge_threshold_out,
    output logic [W-1:0]       edv1_out,
    output logic [W-1:0]       highest_discharge_threshold_out,
    output logic               edv_detect_en_out,
    output logic               smooth_final_out,
    output logic               qualified_discharge_out,
    output logic [W-1:0]       fcc_out,
    output logic               remcap_load_out,
    output logic [W-1:0]       remcap_report_out,
    output logic               cycle_base_fcc_out,
    output logic               charger_indep_out
);
    import cfg_pkg::*;

    // Upper thresholds sit in bits 31:16, so W beyond 16 cannot be served
    if (W < 8 || W > 16)
    begin : g_w_check
        $error("W must lie in 8..16");
    end

    logic [7:0]   flag_cfg_reg;
    logic [15:0]  gauge_cfg_reg;
    logic [W-1:0] fix0_reg, fix1_reg, fix2_reg;
    logic [7:0]   fc_set_soc_reg, fc_clr_soc_reg, fd_set_soc_reg, fd_clr_soc_reg;
    logic [W-1:0] fc_set_v_reg, fc_clr_v_reg, fd_set_v_reg, fd_clr_v_reg;
    logic [W-1:0] overload_reg, low_temp_reg, near_full_reg, reserve_reg;
    logic         fc_reg, fd_reg, gfc_reg, seen_full_reg, qual_reg;
    cfg_lrn_e     lrn_reg;
    logic         fc_next, fd_next;
    logic         fc_set, fc_clr, fd_set, fd_clr;

    // Register writes
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            flag_cfg_reg   <= `CFG_FLAG_CFG_RST;
            gauge_cfg_reg  <= `CFG_GAUGE_CFG_RST;
            fix0_reg       <= '0;
            fix1_reg       <= '0;
            fix2_reg       <= '0;
            fc_set_soc_reg <= `CFG_FC_SET_SOC_RST;
            fc_clr_soc_reg <= `CFG_FC_CLR_SOC_RST;
            fd_set_soc_reg <= `CFG_FD_SET_SOC_RST;
            fd_clr_soc_reg <= `CFG_FD_CLR_SOC_RST;
            fc_set_v_reg   <= '1;
            fc_clr_v_reg   <= '0;
            fd_set_v_reg   <= '0;
            fd_clr_v_reg   <= '1;
            overload_reg   <= '1;
            low_temp_reg   <= '0;
            near_full_reg  <= '0;
            reserve_reg    <= '0;
        end
        else if (ce_in && wr_in)
        begin
            case (addr_in)
                `CFG_OFS_FLAG_CFG:  flag_cfg_reg <= wdata_in[7:0];
                `CFG_OFS_GAUGE_CFG: gauge_cfg_reg <= wdata_in[15:0] & `CFG_GAUGE_CFG_MASK;
                `CFG_OFS_FIX_FINAL_DISCHARGE_THRESHOLD:  fix0_reg <= wdata_in[W-1:0];
                `CFG_OFS_FIX_EDV1:  fix1_reg <= wdata_in[W-1:0];
                `CFG_OFS_FIX_HIGHEST_DISCHARGE_THRESHOLD:  fix2_reg <= wdata_in[W-1:0];
                `CFG_OFS_FC_SOC:
                begin
                    fc_set_soc_reg <= wdata_in[7:0];
                    fc_clr_soc_reg <= wdata_in[15:8];
                end
                `CFG_OFS_FD_SOC:
                begin
                    fd_set_soc_reg <= wdata_in[7:0];
                    fd_clr_soc_reg <= wdata_in[15:8];
                end
                `CFG_OFS_FC_VOLT:
                begin
                    fc_set_v_reg <= wdata_in[W-1:0];
                    fc_clr_v_reg <= wdata_in[16 +: W] ;
                end
                `CFG_OFS_FD_VOLT:
                begin
                    fd_set_v_reg <= wdata_in[W-1:0];
                    fd_clr_v_reg <= wdata_in[16 +: W];
                end
                `CFG_OFS_LIMITS:
                begin
                    overload_reg  <= wdata_in[W-1:0];
                    low_temp_reg  <= wdata_in[16 +: W];
                end
                `CFG_OFS_NEAR_FULL: near_full_reg <= wdata_in[W-1:0];
                `CFG_OFS_RESERVE:   reserve_reg <= wdata_in[W-1:0];
                default: ;
            endcase
        end
    end

    // Flag condition terms
    always_comb
    begin
        fc_clr = flag_cfg_reg[`CFG_B_FC_CLR_SOC] && (soc_in <= fc_clr_soc_reg);
        fc_clr = fc_clr || (flag_cfg_reg[`CFG_B_FC_CLR_V] && (volt_in <= fc_clr_v_reg));
        fc_set = flag_cfg_reg[`CFG_B_FC_SET_SOC] && (soc_in >= fc_set_soc_reg);
        fc_set = fc_set || (flag_cfg_reg[`CFG_B_FC_SET_V] && (volt_in >= fc_set_v_reg));
        fd_clr = flag_cfg_reg[`CFG_B_FD_CLR_SOC] && (soc_in >= fd_clr_soc_reg);
        fd_clr = fd_clr || (flag_cfg_reg[`CFG_B_FD_CLR_V] && (volt_in >= fd_clr_v_reg));
        fd_set = flag_cfg_reg[`CFG_B_FD_SET_SOC] && (soc_in <= fd_set_soc_reg);
        fd_set = fd_set || (flag_cfg_reg[`CFG_B_FD_SET_V] && (volt_in <= fd_set_v_reg));
        fc_next = fc_reg;
        fd_next = fd_reg;
        if (meas_valid_in)
        begin
            if (fc_set)
                fc_next = 1'b1;
            else if (fc_clr)
                fc_next = 1'b0;
            if (fd_set)
                fd_next = 1'b1;
            else if (fd_clr)
                fd_next = 1'b0;
        end
    end

    // Status flags
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            fc_reg  <= 1'b0;
            fd_reg  <= 1'b0;
            gfc_reg <= 1'b0;
        end
        else if (ce_in)
        begin
            fc_reg <= fc_next;
            fd_reg <= fd_next;
            if (charge_term_in)
                gfc_reg <= 1'b1;
            else if (wr_in && addr_in == `CFG_OFS_STATUS && wdata_in[`CFG_B_STAT_GFC])
                gfc_reg <= 1'b0;
        end
    end

    // Learning qualification
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            lrn_reg       <= CFG_LRN_IDLE;
            seen_full_reg <= 1'b0;
            qual_reg      <= 1'b0;
        end
        else if (ce_in)
        begin
            if (charge_term_in)
                seen_full_reg <= 1'b1;
            case (lrn_reg)
                CFG_LRN_IDLE:
                begin
                    qual_reg <= 1'b0;
                    if (!gauge_cfg_reg[`CFG_B_LEARN_FC] || seen_full_reg)
                        lrn_reg <= CFG_LRN_ARMED;
                end
                CFG_LRN_ARMED:
                begin
                    // near full start, still gating it
                    if (discharging_in && remcap_in >= near_full_reg
                        && (!gauge_cfg_reg[`CFG_B_LEARN_FC] || seen_full_reg))
                    begin
                        lrn_reg  <= CFG_LRN_RUN;
                        qual_reg <= 1'b1;
                    end
                end
                CFG_LRN_RUN:
                begin
                    if (temp_in <= low_temp_reg)
                        qual_reg <= 1'b0;
                    if (charge_term_in)
                    begin
                        lrn_reg       <= CFG_LRN_IDLE;
                        seen_full_reg <= 1'b1;
                    end
                end
                default: lrn_reg <= CFG_LRN_IDLE;
            endcase
        end
    end

    // Threshold selection
    always_comb
    begin
        if (gauge_cfg_reg[`CFG_B_COMP])
        begin
            final_discharge_threshold_out = gauge_cfg_reg[`CFG_B_FIXED_FINAL_THRESHOLD_SEL] ? fix0_reg : model_final_discharge_threshold_in;
            edv1_out = model_edv1_in;
            highest_discharge_threshold_out = battery_low_edv_in;
        end
        else
        begin
            final_discharge_threshold_out = fix0_reg;
            edv1_out = fix1_reg;
            highest_discharge_threshold_out = fix2_reg;
        end
    end

    assign edv_detect_en_out = dsg_current_in <= overload_reg;
    assign smooth_final_out = gauge_cfg_reg[`CFG_B_SMOOTH0] && smoothing_enable_ctl_in
                              && smoothing_extension_ctl_in;
    assign fcc_out = (gauge_cfg_reg[`CFG_B_LEARNED_CAPACITY_CAP_EN] && fcc_learned_in > design_cap_in)
                     ? design_cap_in : fcc_learned_in;
    assign remcap_load_out = gauge_cfg_reg[`CFG_B_CAPACITY_SYNC_EN] && charge_term_in;
    assign remcap_report_out = (remcap_in <= reserve_reg) ? '0 : remcap_in - reserve_reg;
    assign cycle_base_fcc_out = gauge_cfg_reg[`CFG_B_CCT];
    assign charger_indep_out = gauge_cfg_reg[`CFG_B_CHARGER];
    assign full_charge_flag_out    = fc_reg;
    assign full_discharge_flag_out = fd_reg;
    assign gauge_full_charge_out   = gfc_reg;
    assign qualified_discharge_out = qual_reg;

    // Read data, one cycle after strobe
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            rdata_out <= '0;
        else if (ce_in)
        begin
            rdata_out <= '0;
            if (rd_in)
            begin
                case (addr_in)
                    `CFG_OFS_FLAG_CFG:  rdata_out <= {24'h000000, flag_cfg_reg};
                    `CFG_OFS_GAUGE_CFG: rdata_out <= {16'h0000, gauge_cfg_reg};
                    `CFG_OFS_STATUS:
                        rdata_out <= {28'h0000000, qual_reg, gfc_reg, fd_reg, fc_reg};
                    `CFG_OFS_FIX_FINAL_DISCHARGE_THRESHOLD:  rdata_out <= 32'(fix0_reg);
                    `CFG_OFS_FIX_EDV1:  rdata_out <= 32'(fix1_reg);
                    `CFG_OFS_FIX_HIGHEST_DISCHARGE_THRESHOLD:  rdata_out <= 32'(fix2_reg);
                    `CFG_OFS_FC_SOC:    rdata_out <= {16'h0000, fc_clr_soc_reg, fc_set_soc_reg};
                    `CFG_OFS_FD_SOC:    rdata_out <= {16'h0000, fd_clr_soc_reg, fd_set_soc_reg};
                    default:            rdata_out <= '0;
                endcase
            end
        end
    end

    full_hold_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        ce_in && !meas_valid_in |=> $stable(fc_reg) && $stable(fd_reg))
        else $error("flag changed without result");
    full_set_soc_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        ce_in && meas_valid_in && flag_cfg_reg[6] && soc_in >= fc_set_soc_reg |=> fc_reg)
        else $error("full flag not set");
    empty_set_soc_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        ce_in && meas_valid_in && flag_cfg_reg[2] && soc_in <= fd_set_soc_reg |=> fd_reg)
        else $error("empty flag not set");
    full_clr_soc_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        ce_in && meas_valid_in && !fc_set && flag_cfg_reg[7] && soc_in <= fc_clr_soc_reg
        |=> !fc_reg) else $error("full flag not cleared");
    term_full_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        ce_in && charge_term_in |=> gfc_reg) else $error("gauging full missing");
    fcc_cap_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        gauge_cfg_reg[8] |-> fcc_out <= design_cap_in) else $error("capacity over design");
    overload_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        dsg_current_in > overload_reg |-> !edv_detect_en_out) else $error("detect in overload");
    fixed_thr_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        !gauge_cfg_reg[3] |-> final_discharge_threshold_out == fix0_reg && highest_discharge_threshold_out == fix2_reg)
        else $error("fixed threshold wrong");
endmodule : cfg_flag_gauge

// ===== verification/cfg_host_model.sv
// Purpose: Host controller model driving the plain register port
// Assumes: Read data stands only in the cycle after the read strobe
// Notes:   Strobes are one cycle long and change right after a rising edge
`timescale 1ns/1ps
module cfg_host_model (
    input  wire logic        mclk_in,
    output logic      [7:0]  addr_out,
    output logic      [31:0] wdata_out,
    output logic             wr_out,
    output logic             rd_out,
    input  wire logic [31:0] rdata_in
);
    // Idle bus from time zero
    initial
    begin
        addr_out  = 8'h00;
        wdata_out = 32'h0000_0000;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
    end

    // One-cycle write strobe beside address and data
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge mclk_in);
        wr_out    <= 1'b0;
        wdata_out <= ~d; // Released data must not keep its old value
    endtask : wr_reg

    // One-cycle read strobe, data taken in the following cycle only
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge mclk_in);
        rd_out   <= 1'b0;
        @(posedge mclk_in);
        d = rdata_in;
    endtask : rd_reg
endmodule : cfg_host_model

// ===== verification/tb.sv
// Purpose: Self-checking bench for the flag and gauging configuration block
// Assumes: Flag set wins over clear; flags move only on a result strobe
// Notes:   Random thresholds kept small so that compares hit both ways
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb;
    localparam int W = 16;
    logic mclk_in, rstn_in, ce_in, wr_in, rd_in, meas_valid_in, charge_term_in, discharging_in;
    logic smoothing_enable_ctl_in, smoothing_extension_ctl_in;
    logic [7:0] addr_in, soc_in;
    logic [31:0] wdata_in, rdata_out, rd;
    logic [W-1:0] volt_in, dsg_current_in, temp_in, remcap_in, fcc_learned_in, design_cap_in;
    logic [W-1:0] model_final_discharge_threshold_in, model_edv1_in, model_highest_discharge_threshold_in, battery_low_edv_in;
    logic full_charge_flag_out, full_discharge_flag_out, gauge_full_charge_out;
    logic edv_detect_en_out, smooth_final_out, qualified_discharge_out, remcap_load_out;
    logic cycle_base_fcc_out, charger_indep_out;
    logic [W-1:0] final_discharge_threshold_out, edv1_out, highest_discharge_threshold_out, fcc_out, remcap_report_out, e0, fcc;
    int miscompares = 0;
    int checks = 0;
    int fc, fd, fcfg, gcfg, v, s, u, ovl, rs;
    int th[4];
    int vt[4];
    int fx[3];

    cfg_flag_gauge #(.W(W)) dut (
        .mclk_in, .rstn_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .meas_valid_in, .soc_in, .volt_in, .dsg_current_in, .temp_in, .remcap_in,
        .fcc_learned_in, .design_cap_in, .model_final_discharge_threshold_in, .model_edv1_in, .model_highest_discharge_threshold_in,
        .battery_low_edv_in, .smoothing_enable_ctl_in, .smoothing_extension_ctl_in,
        .charge_term_in, .discharging_in, .full_charge_flag_out, .full_discharge_flag_out,
        .gauge_full_charge_out, .final_discharge_threshold_out, .edv1_out, .highest_discharge_threshold_out, .edv_detect_en_out,
        .smooth_final_out, .qualified_discharge_out, .fcc_out, .remcap_load_out,
        .remcap_report_out, .cycle_base_fcc_out, .charger_indep_out);

    cfg_host_model host (.mclk_in, .addr_out(addr_in), .wdata_out(wdata_in), .wr_out(wr_in),
        .rd_out(rd_in), .rdata_in(rdata_out));

    // Free-running 50 MHz clock
    initial mclk_in = 1'b0;
    always #10 mclk_in = ~mclk_in;

    // Verdict and end of run
    task automatic end_sim();
        if (miscompares == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    // Read a register and compare the word
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        host.rd_reg(a, rd);
        `CHK("rdata", e, rd)
    endtask : chk_rd

    // Cut a hang short, about eighteen times the expected run
    initial
    begin
        #200000;
        miscompares++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        {ce_in, meas_valid_in, charge_term_in, discharging_in} = 4'b1000;
        {smoothing_enable_ctl_in, smoothing_extension_ctl_in} = 2'b00;
        {soc_in, volt_in, dsg_current_in, temp_in, remcap_in} = '0;
        {fcc_learned_in, design_cap_in, model_final_discharge_threshold_in, model_edv1_in} = '0;
        {model_highest_discharge_threshold_in, battery_low_edv_in} = '0;
        rstn_in = 1'b0;
        void'($urandom(12779));
        repeat (3) @(posedge mclk_in);
        rstn_in <= 1'b1;
        // Reset values, masking and unmapped place
        chk_rd(8'h00, 32'h0000_008C);
        chk_rd(8'h04, 32'h0000_0000);
        chk_rd(8'hFC, 32'h0000_0000);
        host.wr_reg(8'h04, 32'h0000_FFFF);
        chk_rd(8'h04, 32'h0000_153B);
        // Flag set and clear against the reference model
        fc = 0;
        fd = 0;
        for (int i = 0; i < 48; i++)
        begin
            if (i % 8 == 0)
            begin
                fcfg = $urandom % 256;
                foreach (th[k]) th[k] = $urandom % 101;
                foreach (vt[k]) vt[k] = $urandom % 64;
                host.wr_reg(8'h00, 32'(fcfg));
                host.wr_reg(8'h18, 32'((th[1] << 8) | th[0]));
                host.wr_reg(8'h1C, 32'((th[3] << 8) | th[2]));
                host.wr_reg(8'h20, 32'((vt[1] << 16) | vt[0]));
                host.wr_reg(8'h24, 32'((vt[3] << 16) | vt[2]));
            end
            v = $urandom % 2;
            s = $urandom % 101;
            u = $urandom % 64;
            @(posedge mclk_in);
            meas_valid_in <= 1'(v);
            soc_in <= 8'(s);
            volt_in <= W'(u);
            @(posedge mclk_in);
            meas_valid_in <= 1'b0;
            if (v == 1)
            begin
                if ((fcfg[6] && s >= th[0]) || (fcfg[4] && u >= vt[0])) fc = 1;
                else if ((fcfg[7] && s <= th[1]) || (fcfg[5] && u <= vt[1])) fc = 0;
                if ((fcfg[2] && s <= th[2]) || (fcfg[0] && u <= vt[2])) fd = 1;
                else if ((fcfg[3] && s >= th[3]) || (fcfg[1] && u >= vt[3])) fd = 0;
            end
            @(negedge mclk_in);
            `CHK("fc_flag", 1'(fc), full_charge_flag_out)
            `CHK("fd_flag", 1'(fd), full_discharge_flag_out)
            host.rd_reg(8'h08, rd);
            `CHK("status", 4'((fd << 1) | fc), rd[3:0])
        end
        // Gauging configuration steering
        for (int i = 0; i < 16; i++)
        begin
            gcfg = ($urandom % 65536) & 32'h153B;
            foreach (fx[k]) fx[k] = $urandom % 65536;
            ovl = $urandom % 65536;
            host.wr_reg(8'h04, 32'(gcfg));
            host.wr_reg(8'h0C, 32'(fx[0]));
            host.wr_reg(8'h10, 32'(fx[1]));
            host.wr_reg(8'h14, 32'(fx[2]));
            host.wr_reg(8'h28, 32'(ovl));
            @(posedge mclk_in);
            {model_final_discharge_threshold_in, model_edv1_in, model_highest_discharge_threshold_in} <= 48'({$urandom, $urandom});
            battery_low_edv_in <= W'($urandom);
            fcc_learned_in <= W'($urandom);
            design_cap_in <= W'($urandom);
            dsg_current_in <= (i % 2) ? W'(ovl) : W'($urandom);
            {smoothing_enable_ctl_in, smoothing_extension_ctl_in} <= 2'($urandom);
            charge_term_in <= 1'b1;
            @(negedge mclk_in);
            e0 = (gcfg[3] && !gcfg[5]) ? model_final_discharge_threshold_in : W'(fx[0]);
            fcc = (gcfg[8] && fcc_learned_in > design_cap_in) ? design_cap_in : fcc_learned_in;
            `CHK("final_discharge_threshold", e0, final_discharge_threshold_out)
            `CHK("edv1", gcfg[3] ? model_edv1_in : W'(fx[1]), edv1_out)
            `CHK("highest_discharge_threshold", gcfg[3] ? battery_low_edv_in : W'(fx[2]), highest_discharge_threshold_out)
            `CHK("fcc", fcc, fcc_out)
            `CHK("edv_det", 1'(dsg_current_in <= W'(ovl)), edv_detect_en_out)
            `CHK("smooth", gcfg[12] & smoothing_enable_ctl_in & smoothing_extension_ctl_in,
                smooth_final_out)
            `CHK("charger", gcfg[4], charger_indep_out)
            `CHK("cycle", gcfg[0], cycle_base_fcc_out)
            `CHK("sync", gcfg[1], remcap_load_out)
            @(posedge mclk_in);
            charge_term_in <= 1'b0;
            @(negedge mclk_in);
            `CHK("gfc_set", 1'b1, gauge_full_charge_out)
            host.wr_reg(8'h08, 32'h0000_0004);
            @(negedge mclk_in);
            `CHK("gfc_clr", 1'b0, gauge_full_charge_out)
        end
        // Second reset, learning qualification, reserve and clock enable
        @(posedge mclk_in);
        rstn_in <= 1'b0;
        {charge_term_in, discharging_in} <= 2'b00;
        remcap_in <= W'(200);
        temp_in <= W'(50);
        rs = $urandom % 400;
        repeat (3) @(posedge mclk_in);
        rstn_in <= 1'b1;
        chk_rd(8'h08, 32'h0000_0000);
        host.wr_reg(8'h04, 32'h0000_0400);
        host.wr_reg(8'h3C, 32'h0000_0064);
        host.wr_reg(8'h28, 32'h000A_FFFF);
        host.wr_reg(8'h40, 32'(rs));
        @(posedge mclk_in);
        discharging_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        @(negedge mclk_in);
        `CHK("qual_nofc", 1'b0, qualified_discharge_out)
        `CHK("remcap_rep", W'((rs >= 200) ? 0 : 200 - rs), remcap_report_out)
        @(posedge mclk_in);
        charge_term_in <= 1'b1;
        @(posedge mclk_in);
        charge_term_in <= 1'b0;
        @(posedge mclk_in);
        @(negedge mclk_in);
        `CHK("qual_run", 1'b1, qualified_discharge_out)
        @(posedge mclk_in);
        temp_in <= W'(10);
        @(posedge mclk_in);
        @(negedge mclk_in);
        `CHK("qual_cold", 1'b0, qualified_discharge_out)
        chk_rd(8'h08, 32'h0000_0004);
        @(posedge mclk_in);
        ce_in <= 1'b0;
        meas_valid_in <= 1'b1;
        soc_in <= 8'h00;
        @(posedge mclk_in);
        ce_in <= 1'b1;
        @(negedge mclk_in);
        `CHK("fd_frozen", 1'b0, full_discharge_flag_out)
        @(posedge mclk_in);
        meas_valid_in <= 1'b0;
        @(negedge mclk_in);
        `CHK("fd_soc", 1'b1, full_discharge_flag_out)
        end_sim();
    end
endmodule : tb
